// ==== rtl/tvfm_pkg.sv ====
// constants, types and helpers for the temperature / input voltage monitor
package tvfm_pkg;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0] CMD_UT_WARN  = 8'h52;
    localparam logic [7:0] CMD_UT_FAULT = 8'h53;
    localparam logic [7:0] CMD_UT_ACT   = 8'h54;
    localparam logic [7:0] CMD_OV_FAULT = 8'h55;
    localparam logic [7:0] CMD_OV_ACT   = 8'h56;
    localparam logic [7:0] CMD_OV_WARN  = 8'h57;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0] RST_UT_WARN  = 16'he4e0;
    localparam logic [15:0] RST_UT_FAULT = 16'he490;
    localparam logic [7:0]  RST_ACT      = 8'h80;
    localparam logic [15:0] RST_OV_FAULT = 16'hd3a0;
    localparam logic [15:0] RST_OV_WARN  = 16'hd34d;

    // ****************************************
    // response byte fields
    // ****************************************
    localparam int BEH_HI = 7;
    localparam int BEH_LO = 6;
    localparam int TRY_HI = 5;
    localparam int TRY_LO = 3;
    localparam int TIM_HI = 2;
    localparam int TIM_LO = 0;
    localparam logic [1:0] BEH_IGNORE = 2'h0;
    localparam logic [1:0] BEH_DELAY  = 2'h1;
    localparam logic [1:0] BEH_NOW    = 2'h2;
    localparam logic [1:0] BEH_HOLD   = 2'h3;
    localparam logic [2:0] TRY_NONE   = 3'h0;
    localparam logic [2:0] TRY_FOREVR = 3'h7;

    // ****************************************
    // status bit positions
    // ****************************************
    localparam int SW_OTHER_BIT = 0;
    localparam int SW_TEMP_BIT  = 2;
    localparam int SW_INPUT_BIT = 13;
    localparam int ST_UTF_BIT   = 4;
    localparam int ST_UTW_BIT   = 5;
    localparam int SI_OVW_BIT   = 6;
    localparam int SI_OVF_BIT   = 7;

    // ****************************************
    // l11 decode and timing
    // ****************************************
    localparam int         FIX_W    = 48;
    localparam logic [5:0] FIX_FRAC = 6'h10;
    localparam int CLK_PERIOD_NS = 10;
    localparam int UT_UNIT_NS    = 1000000;
    localparam int OV_UNIT_NS    = 1000000;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] data;
    } tvfm_cmd_t;

    typedef struct packed {
        logic [15:0] word;
        logic [7:0]  temp;
        logic [7:0]  vin;
    } tvfm_status_t;

    // mantissa in low 11 bits, exponent in high 5, result has FIX_FRAC fraction bits
    function automatic logic signed [FIX_W-1:0] tvfm_l11_fix(input logic [15:0] w);
        logic signed [FIX_W-1:0] m;
        logic [5:0]              sh;
        m  = {{(FIX_W-11){w[10]}}, w[10:0]};
        sh = {w[15], w[15:11]} + FIX_FRAC;
        return m <<< sh;
    endfunction : tvfm_l11_fix

endpackage : tvfm_pkg

// ==== rtl/tvfm_monitor.sv ====
// fault response sequencer and the temperature / input voltage command registers
`timescale 1ns/1ps

// ****************************************
// one fault response sequencer
// ****************************************
module tvfm_resp
    import tvfm_pkg::*;
#(
    parameter int UNIT_CYC = 100000
)(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // fault and setting
    input  wire logic       fault,
    input  wire logic [7:0] action,
    input  wire logic       restart,
    // result
    output logic            off_q
);

    typedef enum logic [4:0] {
        RS_RUN   = 5'h01,
        RS_DELAY = 5'h02,
        RS_OFF   = 5'h04,
        RS_HOLD  = 5'h08,
        RS_LATCH = 5'h10
    } tvfm_rs_t;

    tvfm_rs_t    state_q;
    tvfm_rs_t    state_d;
    logic [31:0] timer_q;
    logic [31:0] timer_d;
    logic [2:0]  tries_q;
    logic [2:0]  tries_d;

    wire logic [1:0]  beh      = action[BEH_HI:BEH_LO];
    wire logic [2:0]  try_set  = action[TRY_HI:TRY_LO];
    wire logic [31:0] tgt      = 32'(action[TIM_HI:TIM_LO]) * 32'(UNIT_CYC); // RL14
    wire logic        expired  = timer_q >= tgt;
    // retries used up, or none allowed: stay off until a restart
    wire logic        give_up  = (try_set == TRY_NONE) ||                  // RL11
                                 ((try_set != TRY_FOREVR) && (tries_q >= try_set)); // RL12
    wire tvfm_rs_t    off_next = give_up ? RS_LATCH : RS_OFF;

    always_comb
    begin
        state_d = state_q;
        timer_d = timer_q + 32'h1;
        tries_d = tries_q;
        case (state_q)
            RS_RUN:
            begin
                timer_d = 32'h0;
                if (fault && beh == BEH_DELAY)      // RL7
                    state_d = RS_DELAY;
                else if (fault && beh == BEH_NOW)   // RL8
                    state_d = off_next;
                else if (fault && beh == BEH_HOLD)  // RL9
                    state_d = RS_HOLD;
            end
            RS_DELAY:
            begin
                // a fault gone before its delay ran out is not acted on
                if (!fault)
                    state_d = RS_RUN;
                else if (expired)                   // RL7
                begin
                    state_d = off_next;
                    timer_d = 32'h0;
                end
            end
            RS_OFF:
            begin
                // re-enable after the spacing time; fault is judged again in run
                if (expired)                        // RL12 RL13
                begin
                    state_d = RS_RUN;
                    if (try_set != TRY_FOREVR)
                        tries_d = tries_q + 3'h1;
                end
            end
            RS_HOLD:
            begin
                if (!fault)                         // RL9
                    state_d = RS_RUN;
            end
            RS_LATCH:
            begin
                timer_d = 32'h0;                    // RL11
            end
            default:
            begin
                state_d = RS_RUN;
            end
        endcase
        if (restart)
        begin
            state_d = RS_RUN;
            tries_d = 3'h0;
            timer_d = 32'h0;
        end
    end

    wire logic off_d = (state_d == RS_OFF) || (state_d == RS_HOLD) ||
                       (state_d == RS_LATCH);       // RL6

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_q <= RS_RUN;
            timer_q <= 32'h0;
            tries_q <= 3'h0;
            off_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            timer_q <= timer_d;
            tries_q <= tries_d;
            off_q   <= off_d;
        end
    end

endmodule : tvfm_resp

// Notes on behaviour
// RL1 - falling below warning sets temp status, alerts
// RL2 - warning threshold word, resets to e4e0
// RL3 - fault threshold word, resets to e490
// RL4 - under-temp fault clears above warning threshold
// RL5 - under-temp response byte resets to 80
// RL6 - behaviour 00 ignores the fault
// RL7 - behaviour 01 delays, disables, then retries
// RL8 - behaviour 10 disables at once, retries
// RL9 - behaviour 11 off only while faulted
// RL10 - fault bits sticky until clear-faults
// RL11 - retry 000 stays off until restart
// RL12 - retry 1-6 restarts that many times
// RL13 - retry 111 restarts forever
// RL14 - time field sets delay and spacing
// RL15 - overvoltage fault word, resets to d3a0
// RL16 - overvoltage response byte resets to 80
// RL17 - above warning sets input status, alerts
// RL18 - overvoltage warning word, resets to d34d
// RL19 - thresholds two bytes, responses one byte
// RL20 - temperature summary in status bit 2
// RL21 - thresholds decoded from l11 before comparing
// RL22 - alert held until clear-faults
module tvfm_monitor
    import tvfm_pkg::*;
#(
    parameter int UT_UNIT_CYC = UT_UNIT_NS / CLK_PERIOD_NS,
    parameter int OV_UNIT_CYC = OV_UNIT_NS / CLK_PERIOD_NS
)(
    // clock and reset
    input  wire logic   clk,
    input  wire logic   nrst,
    // command port
    input  tvfm_cmd_t   cmd,
    input  wire logic   clear_faults,
    input  wire logic   restart,
    // measurements, l11 words
    input  wire logic [15:0] temp_meas,
    input  wire logic [15:0] vin_meas,
    // read answer
    output logic [15:0] rd_data_q,
    output logic        rd_valid_q,
    output logic        cmd_err_q,
    // status and output control
    output tvfm_status_t status_q,
    output logic        alert_n_q,
    output logic        out_en_q
);

    // ****************************************
    // command registers
    // ****************************************
    logic [15:0] utw_q;
    logic [15:0] utf_q;
    logic [7:0]  uta_q;
    logic [15:0] ovf_q;
    logic [7:0]  ova_q;
    logic [15:0] ovw_q;

    wire logic hit_utw = cmd.code == CMD_UT_WARN;
    wire logic hit_utf = cmd.code == CMD_UT_FAULT;
    wire logic hit_uta = cmd.code == CMD_UT_ACT;
    wire logic hit_ovf = cmd.code == CMD_OV_FAULT;
    wire logic hit_ova = cmd.code == CMD_OV_ACT;
    wire logic hit_ovw = cmd.code == CMD_OV_WARN;
    wire logic hit_any = hit_utw | hit_utf | hit_uta | hit_ovf | hit_ova | hit_ovw;
    wire logic wr      = cmd.valid & cmd.write;
    wire logic rd      = cmd.valid & ~cmd.write;

    // byte commands read back in the low byte, upper byte zero
    wire logic [15:0] rd_mux =
        hit_utw ? utw_q :
        hit_utf ? utf_q :
        hit_uta ? {8'h0, uta_q} :
        hit_ovf ? ovf_q :
        hit_ova ? {8'h0, ova_q} :
        hit_ovw ? ovw_q : 16'h0;                       // RL19

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            utw_q <= RST_UT_WARN;                      // RL2
            utf_q <= RST_UT_FAULT;                     // RL3
            uta_q <= RST_ACT;                          // RL5
            ovf_q <= RST_OV_FAULT;                     // RL15
            ova_q <= RST_ACT;                          // RL16
            ovw_q <= RST_OV_WARN;                      // RL18
        end
        else
        begin
            if (wr && hit_utw) utw_q <= cmd.data;
            if (wr && hit_utf) utf_q <= cmd.data;
            if (wr && hit_uta) uta_q <= cmd.data[7:0]; // RL19
            if (wr && hit_ovf) ovf_q <= cmd.data;
            if (wr && hit_ova) ova_q <= cmd.data[7:0];
            if (wr && hit_ovw) ovw_q <= cmd.data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rd_data_q  <= 16'h0;
            rd_valid_q <= 1'b0;
            cmd_err_q  <= 1'b0;
        end
        else
        begin
            rd_data_q  <= rd ? rd_mux : 16'h0;
            rd_valid_q <= rd & hit_any;
            cmd_err_q  <= cmd.valid & ~hit_any;
        end
    end

    // ****************************************
    // threshold comparison
    // ****************************************
    wire logic signed [FIX_W-1:0] temp_fix = tvfm_l11_fix(temp_meas);  // RL21
    wire logic signed [FIX_W-1:0] vin_fix  = tvfm_l11_fix(vin_meas);
    wire logic signed [FIX_W-1:0] utw_fix  = tvfm_l11_fix(utw_q);
    wire logic signed [FIX_W-1:0] utf_fix  = tvfm_l11_fix(utf_q);
    wire logic signed [FIX_W-1:0] ovf_fix  = tvfm_l11_fix(ovf_q);
    wire logic signed [FIX_W-1:0] ovw_fix  = tvfm_l11_fix(ovw_q);

    wire logic ut_warn_now  = temp_fix < utw_fix;      // RL1
    wire logic ut_fault_now = temp_fix < utf_fix;      // RL3
    wire logic ut_clear_now = temp_fix > utw_fix;
    wire logic ov_warn_now  = vin_fix > ovw_fix;       // RL17
    wire logic ov_fault_now = vin_fix > ovf_fix;

    // fault level with hysteresis: drops only once above the warning level
    logic ut_fault_q;
    wire logic ut_fault_d = ut_fault_now | (ut_fault_q & ~ut_clear_now); // RL4

    // ****************************************
    // sticky status, set wins over clear
    // ****************************************
    wire logic utw_st_d = ut_warn_now | (status_q.temp[ST_UTW_BIT] & ~clear_faults);
    wire logic utf_st_d = ut_fault_d  | (status_q.temp[ST_UTF_BIT] & ~clear_faults); // RL10
    wire logic ovw_st_d = ov_warn_now | (status_q.vin[SI_OVW_BIT] & ~clear_faults);
    wire logic ovf_st_d = ov_fault_now | (status_q.vin[SI_OVF_BIT] & ~clear_faults); // RL10

    tvfm_status_t status_d;
    always_comb
    begin
        status_d = '0;
        status_d.temp[ST_UTW_BIT]   = utw_st_d;                  // RL1
        status_d.temp[ST_UTF_BIT]   = utf_st_d;
        status_d.vin[SI_OVW_BIT]    = ovw_st_d;                  // RL17
        status_d.vin[SI_OVF_BIT]    = ovf_st_d;
        status_d.word[SW_TEMP_BIT]  = utw_st_d | utf_st_d;       // RL20
        status_d.word[SW_INPUT_BIT] = ovw_st_d | ovf_st_d;       // RL17
        status_d.word[SW_OTHER_BIT] = ovw_st_d | ovf_st_d;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ut_fault_q <= 1'b0;
            status_q   <= '0;
            alert_n_q  <= 1'b1;
        end
        else
        begin
            ut_fault_q <= ut_fault_d;
            status_q   <= status_d;
            alert_n_q  <= ~(|status_d.temp | |status_d.vin);    // RL22
        end
    end

    // ****************************************
    // fault responses
    // ****************************************
    logic ut_off_q;
    logic ov_off_q;

    tvfm_resp #(
        .UNIT_CYC (UT_UNIT_CYC)
    ) u_ut_resp (
        .clk     (clk),
        .nrst    (nrst),
        .fault   (ut_fault_q),
        .action  (uta_q),
        .restart (restart),
        .off_q   (ut_off_q)
    );

    tvfm_resp #(
        .UNIT_CYC (OV_UNIT_CYC)
    ) u_ov_resp (
        .clk     (clk),
        .nrst    (nrst),
        .fault   (ov_fault_now),
        .action  (ova_q),
        .restart (restart),
        .off_q   (ov_off_q)
    );

    always_ff @(posedge clk)
    begin
        if (!nrst)
            out_en_q <= 1'b0;
        else
            out_en_q <= ~(ut_off_q | ov_off_q);                 // RL6
    end

endmodule : tvfm_monitor

// ==== tb/tvfm_monitor_asserts.sv ====
// concurrent checks on the monitor ports
`timescale 1ns/1ps
module tvfm_monitor_chk
    import tvfm_pkg::*;
#(
    parameter int UT_UNIT_CYC = 4,
    parameter int OV_UNIT_CYC = 4
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // inputs
    input  tvfm_cmd_t        cmd,
    input  wire logic        clear_faults,
    input  wire logic        restart,
    input  wire logic [15:0] temp_meas,
    input  wire logic [15:0] vin_meas,
    // outputs
    input  wire logic [15:0] rd_data_q,
    input  wire logic        rd_valid_q,
    input  wire logic        cmd_err_q,
    input  tvfm_status_t     status_q,
    input  wire logic        alert_n_q,
    input  wire logic        out_en_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire mapped = (cmd.code >= 8'h52) && (cmd.code <= 8'h57);

    // ********
    // requests
    // ********
    sequence s_read;
        cmd.valid && !cmd.write && mapped;
    endsequence
    sequence s_bad;
        cmd.valid && !mapped;
    endsequence
    sequence s_write;
        cmd.valid && cmd.write && mapped;
    endsequence

    a_read_answer: assert property (s_read |=> rd_valid_q && !cmd_err_q)
        else $error("read left unanswered");
    a_bad_code: assert property (s_bad |=> cmd_err_q && !rd_valid_q && !(|rd_data_q))
        else $error("unmapped code not refused");
    a_write_quiet: assert property (s_write |=> !rd_valid_q && !cmd_err_q)
        else $error("write gave an answer");
    a_answer_cause: assert property (rd_valid_q |-> $past(cmd.valid) && !$past(cmd.write))
        else $error("answer without read");
    a_temp_summary: assert property (status_q.word[2] == (status_q.temp[5] | status_q.temp[4]))
        else $error("temperature summary wrong");
    a_input_summary: assert property (status_q.word[13] == (status_q.vin[7] | status_q.vin[6])
        && status_q.word[0] == status_q.word[13]) else $error("input summary wrong");
    a_alert_level: assert property (alert_n_q == !(|status_q))
        else $error("alert not tied to status");
    a_ovf_sticky: assert property (status_q.vin[7] && !clear_faults |=> status_q.vin[7])
        else $error("fault bit lost");
    a_utf_sticky: assert property (status_q.temp[4] && !clear_faults |=> status_q.temp[4])
        else $error("under-temp fault lost");
    a_alert_release: assert property ($rose(alert_n_q) |-> $past(clear_faults))
        else $error("alert released without clear");
    // restart forces both sequencers to run, so the output is back two edges later
    a_restart_on: assert property (restart |-> ##2 out_en_q)
        else $error("output not enabled after restart");
    a_read_idle: assert property (!rd_valid_q |-> !(|rd_data_q))
        else $error("read data outside its answer cycle");
endmodule : tvfm_monitor_chk

bind tvfm_monitor tvfm_monitor_chk #(.UT_UNIT_CYC(UT_UNIT_CYC), .OV_UNIT_CYC(OV_UNIT_CYC))
    tvfm_monitor_chk_inst (.clk, .nrst, .cmd, .clear_faults, .restart, .temp_meas, .vin_meas,
    .rd_data_q, .rd_valid_q, .cmd_err_q, .status_q, .alert_n_q, .out_en_q);

// ==== tb/tvfm_host.sv ====
// host model issuing commands to the monitor
`timescale 1ns/1ps
module tvfm_host
    import tvfm_pkg::*;
(
    // clock
    input  wire logic        clk,
    // command side
    output tvfm_cmd_t        cmd,
    input  wire logic [15:0] rd_data_q,
    input  wire logic        rd_valid_q,
    input  wire logic        cmd_err_q
);
    initial cmd = '0;

    // one command held for one edge; idle fields inverted so stale data never matches
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] v,
        output logic [15:0] d, output logic [1:0] a);
        @(negedge clk);
        cmd = '{1'b1, w, c, v};
        @(negedge clk);
        cmd = '{1'b0, 1'b0, ~c, ~v};
        d = rd_data_q;
        a = {rd_valid_q, cmd_err_q};
    endtask : xfer
endmodule : tvfm_host

// ==== tb/testbench.sv ====
// self-checking bench for the temperature and input voltage monitor
`timescale 1ns/1ps
module testbench;
    import tvfm_pkg::*;
    logic         clk = 1'b0;
    logic         nrst = 1'b0;
    logic         clear_faults = 1'b0;
    logic         restart = 1'b0;
    logic [15:0]  temp_meas = 16'he190;
    logic [15:0]  vin_meas = 16'hd300;
    tvfm_cmd_t    cmd;
    logic [15:0]  rd_data_q;
    logic         rd_valid_q;
    logic         cmd_err_q;
    tvfm_status_t status_q;
    logic         alert_n_q;
    logic         out_en_q;
    int           n_mismatch = 0;
    int           num_checks = 0;

    always #5 clk = ~clk;

    // short time unit keeps retry spacing to a few cycles
    tvfm_monitor #(.UT_UNIT_CYC(4), .OV_UNIT_CYC(4)) tvfm_monitor_inst (.clk, .nrst, .cmd,
        .clear_faults, .restart, .temp_meas, .vin_meas, .rd_data_q, .rd_valid_q, .cmd_err_q,
        .status_q, .alert_n_q, .out_en_q);
    tvfm_host tvfm_host_inst (.clk, .cmd, .rd_data_q, .rd_valid_q, .cmd_err_q);

    // ********
    // helpers
    // ********
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        num_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic strobe(input logic clr);
        @(negedge clk);
        if (clr) clear_faults = 1'b1;
        else restart = 1'b1;
        @(negedge clk);
        clear_faults = 1'b0;
        restart = 1'b0;
    endtask : strobe

    task automatic wr(input logic [7:0] c, input logic [15:0] v);
        logic [15:0] d;
        logic [1:0]  a;
        tvfm_host_inst.xfer(1'b1, c, v, d, a);
    endtask : wr

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    // ********
    // scenarios
    // ********
    task automatic t_regs;
        logic [7:0]  c [6] = '{8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57};
        logic [15:0] r [6] = '{16'he4e0, 16'he490, 16'h0080, 16'hd3a0, 16'h0080, 16'hd34d};
        logic [15:0] d;
        logic [1:0]  a;
        for (int i = 0; i < 6; i++)
        begin
            tvfm_host_inst.xfer(1'b0, c[i], 16'h0000, d, a);
            chk(d, r[i], "reset value");
            chk({14'h0, a}, 16'h0002, "read answer");
            wr(c[i], r[i] ^ ((i == 2 || i == 4) ? 16'hff01 : 16'h0001));
            tvfm_host_inst.xfer(1'b0, c[i], 16'h0000, d, a);
            chk(d, r[i] ^ 16'h0001, "read back");
        end
        tvfm_host_inst.xfer(1'b0, 8'h58, 16'h0000, d, a);
        chk({a, d[13:0]}, 16'h4000, "unmapped read");
        tvfm_host_inst.xfer(1'b1, 8'h51, 16'h1234, d, a);
        chk({14'h0, a}, 16'h0001, "unmapped write");
        $display("t_regs end");
    endtask : t_regs

    task automatic t_warn;
        temp_meas = 16'he4c0;
        vin_meas = 16'hd360;
        cyc(2);
        chk(status_q.word, 16'h2005, "warn summary");
        chk({status_q.temp, status_q.vin}, 16'h2040, "warn bits");
        chk(16'(alert_n_q), 16'h0000, "alert low");
        strobe(1'b1);
        chk(status_q.word, 16'h2005, "clear refused");
        temp_meas = 16'he190;
        vin_meas = 16'hd300;
        cyc(2);
        strobe(1'b1);
        chk(status_q.word, 16'h0000, "cleared");
        chk(16'(alert_n_q), 16'h0001, "alert released");
        $display("t_warn end");
    endtask : t_warn

    task automatic t_ut_hold;
        wr(8'h54, 16'h00c0);
        temp_meas = 16'he440;
        cyc(4);
        chk(16'(status_q.temp[4]), 16'h0001, "ut fault");
        chk(16'(out_en_q), 16'h0000, "held off");
        temp_meas = 16'he4c0;
        cyc(6);
        chk(16'(out_en_q), 16'h0000, "hysteresis");
        temp_meas = 16'he190;
        cyc(5);
        chk(16'(out_en_q), 16'h0001, "back on");
        strobe(1'b1);
        $display("t_ut_hold end");
    endtask : t_ut_hold

    task automatic t_ov(input logic [7:0] act, input int lo, input int hi);
        int   falls;
        logic prev;
        falls = 0;
        prev = 1'b1;
        wr(8'h56, {8'h00, act});
        vin_meas = 16'hd3c0;
        repeat (150)
        begin
            @(negedge clk);
            if (prev && !out_en_q) falls++;
            prev = out_en_q;
        end
        chk(16'(status_q.vin[7]), 16'h0001, "ov fault bit");
        chk(16'(falls >= lo && falls <= hi), 16'h0001, "off count");
        vin_meas = 16'hd300;
        strobe(1'b0);
        strobe(1'b1);
        cyc(3);
        chk(16'(out_en_q), 16'h0001, "restarted");
        $display("t_ov %h end", act);
    endtask : t_ov

    task automatic t_delay;
        wr(8'h56, 16'h0043);
        vin_meas = 16'hd3c0;
        cyc(6);
        vin_meas = 16'hd300;
        cyc(14);
        chk(16'(out_en_q), 16'h0001, "short fault");
        strobe(1'b1);
        vin_meas = 16'hd3c0;
        cyc(9);
        chk(16'(out_en_q), 16'h0001, "delaying");
        cyc(9);
        chk(16'(out_en_q), 16'h0000, "off after delay");
        vin_meas = 16'hd300;
        strobe(1'b0);
        strobe(1'b1);
        $display("t_delay end");
    endtask : t_delay

    initial
    begin
        cyc(2);
        nrst = 1'b1;
        @(negedge clk);
        chk(16'(out_en_q), 16'h0001, "run after reset");
        t_regs;
        t_warn;
        t_ut_hold;
        t_ov(8'h00, 0, 0);
        t_ov(8'h80, 1, 1);
        t_ov(8'h91, 3, 3);
        t_ov(8'hb9, 20, 30);
        t_delay;
        finish_test;
    end

    // about thirteen times the expected run
    initial
    begin
        #100000;
        n_mismatch++;
        finish_test;
    end
endmodule : testbench
